//--- tb/pmb_phy_model.sv
// Behavioural PHY on the far side of the RGMII pins, with its register agent
`timescale 1ns/1ps
module pmb_phy_model #(
	parameter logic [15:0] TIMING_RST = 16'h0003,
	parameter logic [15:0] DELAY_RST = 16'h0077
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic txc_in,
	input wire logic [3:0] txd_in,
	input wire logic tx_ctrl_in,
	output logic rx_clk_out,
	output logic [3:0] rxd_out,
	output logic rx_ctrl_out,
	input wire logic req_in,
	input wire logic write_in,
	input wire logic [8:0] addr_in,
	input wire logic [15:0] wdata_in,
	output logic ack_out,
	output logic [15:0] rdata_out
);
	//==============================================================
	// Register agent
	logic [15:0] mem [512];
	logic [24:0] wlog [$];
	int ack_wait = 0;
	int cnt;
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ack_out <= 1'b0;
			cnt <= 0;
			rdata_out <= 16'h0000;
			foreach (mem[i]) mem[i] <= 16'h0000;
			// Shift mode on both paths, 2ns delay code; values are arbitrary
			mem[9'h032] <= TIMING_RST;
			mem[9'h086] <= DELAY_RST;
		end else if (ack_out) begin
			ack_out <= 1'b0;
			cnt <= 0;
			rdata_out <= ~rdata_out;
		end else if (req_in && cnt >= ack_wait) begin
			ack_out <= 1'b1;
			rdata_out <= mem[addr_in];
			// Isolate bit has no effect on any pin here
			if (write_in) begin
				mem[addr_in] <= wdata_in;
				wlog.push_back({addr_in, wdata_in});
			end
		end else begin
			cnt <= req_in ? cnt + 1 : 0;
			rdata_out <= ~rdata_out;
		end
	end
	//==============================================================
	// Receive side: clock only while a nibble task runs, between frames too; full halves only
	initial begin
		rx_clk_out = 1'b0;
		rxd_out = 4'h0;
		rx_ctrl_out = 1'b0;
	end
	task automatic rx_nib(input logic [3:0] n, input logic dv, input logic er);
		rxd_out = n;
		rx_ctrl_out = dv;
		#40 rx_clk_out = 1'b1;
		#40 rx_ctrl_out = dv ^ er;
		#40 rx_clk_out = 1'b0;
		#40;
	endtask : rx_nib
	task automatic rx_byte(input logic [7:0] d, input logic er);
		rx_nib(d[3:0], 1'b1, er);
		rx_nib(d[7:4], 1'b1, er);
	endtask : rx_byte
	task automatic rx_stop();
		rxd_out = ~rxd_out;
		rx_ctrl_out = 1'b0;
	endtask : rx_stop
	//==============================================================
	// Transmit monitor; delayed copies give the value standing before each edge
	logic [3:0] txd_d, nib_r, lo;
	logic ctl_d, en_r, er_lo, phase;
	logic [8:0] txq [$];
	int n_rise, n_bad;
	time t_last, period;
	assign #1 txd_d = txd_in;
	assign #1 ctl_d = tx_ctrl_in;
	initial begin
		n_rise = 0;
		n_bad = 0;
		t_last = 0;
		period = 0;
		phase = 1'b0;
		en_r = 1'b0;
	end
	always @(posedge txc_in) begin
		n_rise++;
		period = $time - t_last;
		t_last = $time;
		nib_r = txd_d;
		en_r = ctl_d;
	end
	always @(negedge txc_in) begin
		if (!en_r) begin
			n_bad += (ctl_d !== 1'b0);
			phase = 1'b0;
		end else begin
			n_bad += (txd_d !== nib_r);
			if (!phase) begin
				lo = nib_r;
				er_lo = ~ctl_d;
			end else begin
				txq.push_back({er_lo | ~ctl_d, nib_r, lo});
			end
			phase = ~phase;
		end
	end
endmodule : pmb_phy_model

//--- tb/tb.sv
// Self-checking bench for the MAC-side RGMII controller
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
	localparam logic [15:0] tim_rst = 16'h0003;
	localparam logic [1:0] rsp_ok = pmb_pkg::RESP_OKAY;
	localparam logic [1:0] rsp_err = pmb_pkg::RESP_SLVERR;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic [1:0] r;} pmb_row_t;
	pmb_row_t rows [9] = '{
		'{1'b0, pmb_pkg::REG_CTRL, 32'h0, 32'h0, rsp_ok},
		'{1'b0, pmb_pkg::REG_STATUS, 32'h0, 32'h0, rsp_ok},
		'{1'b0, pmb_pkg::REG_DEV_CMD, 32'h0, 32'h0, rsp_ok},
		'{1'b0, pmb_pkg::REG_RX_COUNT, 32'h0, 32'h0, rsp_ok},
		'{1'b0, 8'h14, 32'h0, 32'h0, rsp_err},
		'{1'b1, 8'h14, 32'h0, 32'h0, rsp_err},
		'{1'b1, pmb_pkg::REG_STATUS, 32'hffffffff, 32'h0, rsp_ok},
		'{1'b1, pmb_pkg::REG_CTRL, 32'h6, 32'h0, rsp_ok},
		'{1'b0, pmb_pkg::REG_STATUS, 32'h0, 32'h80, rsp_ok}};
	logic [8:0] tx_b [3] = '{9'h03c, 9'h1a7, 9'h081};
	logic [8:0] rx_b [3] = '{9'h05a, 9'h1c3, 9'h00f};
	logic CLOCK_IN, RST_N_IN, AWVALID_IN, WVALID_IN, BREADY_IN, ARVALID_IN, RREADY_IN;
	logic [7:0] AWADDR_IN, ARADDR_IN, TX_DATA_IN, RX_DATA_OUT;
	logic [31:0] WDATA_IN, RDATA_OUT, d;
	logic [3:0] WSTRB_IN, TXD_OUT, RXD_IN;
	logic AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT, TX_CTRL_OUT;
	logic [1:0] BRESP_OUT, RRESP_OUT, r;
	logic GIGABIT_TRANSMIT_CLOCK_OUT, RX_CLK_IN, RX_CTRL_IN, TX_VALID_IN, TX_ERROR_IN;
	logic TX_READY_OUT, RX_VALID_OUT, RX_ERROR_OUT, DEV_REQ_OUT, DEV_WRITE_OUT, DEV_ACK_IN;
	logic [8:0] DEV_ADDR_OUT;
	logic [15:0] DEV_WDATA_OUT, DEV_RDATA_IN;
	logic [8:0] rxq [$];
	int n_mismatch = 0;
	int samples_checked = 0;
	pmb_phy_mac_ctrl dut_u (.CLOCK_IN, .RST_N_IN, .AWADDR_IN, .AWVALID_IN, .AWREADY_OUT,
		.WDATA_IN, .WSTRB_IN, .WVALID_IN, .WREADY_OUT, .BRESP_OUT, .BVALID_OUT, .BREADY_IN,
		.ARADDR_IN, .ARVALID_IN, .ARREADY_OUT, .RDATA_OUT, .RRESP_OUT, .RVALID_OUT, .RREADY_IN,
		.GIGABIT_TRANSMIT_CLOCK_OUT, .TXD_OUT, .TX_CTRL_OUT, .RX_CLK_IN, .RXD_IN, .RX_CTRL_IN,
		.TX_DATA_IN, .TX_VALID_IN, .TX_ERROR_IN, .TX_READY_OUT, .RX_DATA_OUT, .RX_VALID_OUT,
		.RX_ERROR_OUT, .DEV_REQ_OUT, .DEV_WRITE_OUT, .DEV_ADDR_OUT, .DEV_WDATA_OUT,
		.DEV_ACK_IN, .DEV_RDATA_IN);
	pmb_phy_model #(.TIMING_RST(tim_rst)) phy_u (.clk_in(CLOCK_IN), .rst_n_in(RST_N_IN),
		.txc_in(GIGABIT_TRANSMIT_CLOCK_OUT), .txd_in(TXD_OUT), .tx_ctrl_in(TX_CTRL_OUT),
		.rx_clk_out(RX_CLK_IN), .rxd_out(RXD_IN), .rx_ctrl_out(RX_CTRL_IN),
		.req_in(DEV_REQ_OUT), .write_in(DEV_WRITE_OUT), .addr_in(DEV_ADDR_OUT),
		.wdata_in(DEV_WDATA_OUT), .ack_out(DEV_ACK_IN), .rdata_out(DEV_RDATA_IN));
	//==============================================================
	// Bus and stream tasks
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rr);
		AWADDR_IN <= a;
		WDATA_IN <= v;
		AWVALID_IN <= 1'b1;
		WVALID_IN <= 1'b1;
		do @(posedge CLOCK_IN); while (AWREADY_OUT !== 1'b1 || WREADY_OUT !== 1'b1);
		AWVALID_IN <= 1'b0;
		WVALID_IN <= 1'b0;
		BREADY_IN <= 1'b1;
		do @(posedge CLOCK_IN); while (BVALID_OUT !== 1'b1);
		rr = BRESP_OUT;
		BREADY_IN <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
		ARADDR_IN <= a;
		ARVALID_IN <= 1'b1;
		do @(posedge CLOCK_IN); while (ARREADY_OUT !== 1'b1);
		ARVALID_IN <= 1'b0;
		RREADY_IN <= 1'b1;
		do @(posedge CLOCK_IN); while (RVALID_OUT !== 1'b1);
		v = RDATA_OUT;
		rr = RRESP_OUT;
		RREADY_IN <= 1'b0;
	endtask : axi_rd
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] rr;
		axi_wr(a, v, rr);
		`CHK(rr, rsp_ok)
	endtask : wr
	task automatic wait_idle();
		do axi_rd(pmb_pkg::REG_STATUS, d, r); while (d[pmb_pkg::ST_BUSY] !== 1'b0);
	endtask : wait_idle
	task automatic send_tx(input logic [8:0] b);
		TX_DATA_IN <= b[7:0];
		TX_ERROR_IN <= b[8];
		TX_VALID_IN <= 1'b1;
		do @(posedge CLOCK_IN); while (TX_READY_OUT !== 1'b1);
	endtask : send_tx
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	//==============================================================
	// Clock, watchdog, receive monitor
	initial begin
		CLOCK_IN = 1'b0;
		forever #10 CLOCK_IN = ~CLOCK_IN;
	end
	initial begin
		#200_000;
		n_mismatch++;
		stop_test();
	end
	always @(posedge CLOCK_IN) begin
		if (RX_VALID_OUT === 1'b1) rxq.push_back({RX_ERROR_OUT, RX_DATA_OUT});
	end
	//==============================================================
	// Main sequence
	initial begin
		{RST_N_IN, AWVALID_IN, WVALID_IN, BREADY_IN, ARVALID_IN, RREADY_IN} = 6'h00;
		{AWADDR_IN, ARADDR_IN, WDATA_IN, TX_DATA_IN} = 56'h0;
		{WSTRB_IN, TX_VALID_IN, TX_ERROR_IN} = 6'h3c;
		repeat (3) @(posedge CLOCK_IN);
		`CHK({GIGABIT_TRANSMIT_CLOCK_OUT, TX_CTRL_OUT, DEV_REQ_OUT}, 3'b000)
		@(posedge CLOCK_IN);
		RST_N_IN <= 1'b1;
		@(posedge CLOCK_IN);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				axi_wr(rows[i].a, rows[i].d, r);
			end else begin
				axi_rd(rows[i].a, d, r);
				`CHK(d, rows[i].x)
			end
			`CHK(r, rows[i].r)
		end
		`CHK(phy_u.n_rise, 0)
		// Single device write, then read of an untouched default
		wr(pmb_pkg::REG_DEV_DATA, 32'h000000a5);
		wr(pmb_pkg::REG_DEV_CMD, 32'h00030086);
		wait_idle();
		`CHK(phy_u.mem[9'h086], 16'h00a5)
		wr(pmb_pkg::REG_DEV_CMD, 32'h00020032);
		wait_idle();
		axi_rd(pmb_pkg::REG_DEV_DATA, d, r);
		`CHK(d[31:16], tim_rst)
		// Mode sequence toward fibre, then toward copper, with a slow agent
		phy_u.ack_wait = 5;
		phy_u.wlog.delete();
		wr(pmb_pkg::REG_CTRL, 32'h8);
		wr(pmb_pkg::REG_DEV_CMD, 32'h00060000);
		wait_idle();
		`CHK(phy_u.wlog.size(), 2)
		`CHK(phy_u.wlog[0], {9'h018, 16'h000e})
		`CHK(phy_u.wlog[1], {9'h1df, 16'h0062})
		wr(pmb_pkg::REG_CTRL, 32'h0);
		wr(pmb_pkg::REG_DEV_CMD, 32'h00040000);
		wait_idle();
		`CHK(phy_u.wlog[3], {9'h1df, 16'h0060})
		// Transmit: held low before confirmation, then back-to-back bytes
		wr(pmb_pkg::REG_CTRL, 32'h1);
		repeat (20) @(posedge CLOCK_IN);
		`CHK(phy_u.n_rise, 0)
		wr(pmb_pkg::REG_CTRL, 32'h5);
		foreach (tx_b[i]) send_tx(tx_b[i]);
		TX_VALID_IN <= 1'b0;
		repeat (20) @(posedge CLOCK_IN);
		`CHK(phy_u.period, 40)
		foreach (tx_b[i]) `CHK(phy_u.txq[i], tx_b[i])
		wr(pmb_pkg::REG_CTRL, 32'h4);
		send_tx(9'h06e);
		TX_VALID_IN <= 1'b0;
		repeat (100) @(posedge CLOCK_IN);
		`CHK(phy_u.period, 400)
		`CHK(phy_u.txq[3], 9'h06e)
		`CHK(phy_u.n_bad, 0)
		// Receive a frame with one errored byte, then in-band status
		wr(pmb_pkg::REG_CTRL, 32'h15);
		phy_u.rx_nib(4'h0, 1'b0, 1'b0);
		foreach (rx_b[i]) phy_u.rx_byte(rx_b[i][7:0], rx_b[i][8]);
		repeat (3) phy_u.rx_nib(4'hb, 1'b0, 1'b0);
		phy_u.rx_stop();
		repeat (10) @(posedge CLOCK_IN);
		`CHK(rxq.size(), 3)
		foreach (rx_b[i]) `CHK(rxq[i], rx_b[i])
		axi_rd(pmb_pkg::REG_STATUS, d, r);
		`CHK(d[7:0], 8'h4b)
		wr(pmb_pkg::REG_CTRL, 32'h35);
		axi_rd(pmb_pkg::REG_STATUS, d, r);
		`CHK(d[7:0], 8'h5b)
		axi_rd(pmb_pkg::REG_RX_COUNT, d, r);
		`CHK(d, 32'h00010003)
		wr(pmb_pkg::REG_RX_COUNT, 32'h0);
		axi_rd(pmb_pkg::REG_RX_COUNT, d, r);
		`CHK(d, 32'h0)
		// Reset in mid-run with the link clock running
		RST_N_IN <= 1'b0;
		repeat (2) @(posedge CLOCK_IN);
		`CHK({GIGABIT_TRANSMIT_CLOCK_OUT, TX_CTRL_OUT, DEV_REQ_OUT}, 3'b000)
		RST_N_IN <= 1'b1;
		@(posedge CLOCK_IN);
		axi_rd(pmb_pkg::REG_CTRL, d, r);
		`CHK(d, 32'h0)
		stop_test();
	end
endmodule : tb

//--- verilog/pmb_link_if.sv
// Interface between the controller core and its RGMII transmit and receive ends
`timescale 1ns/1ps
interface pmb_link_if;
	pmb_pkg::pmb_speed_t speed;
	logic run;
	logic [7:0] tx_data;
	logic tx_valid;
	logic tx_er;
	logic tx_take;
	logic clk_running;
	logic [7:0] rx_data;
	logic rx_valid;
	logic rx_err;
	logic [3:0] ib_status;
	modport ctl (output speed, run, tx_data, tx_valid, tx_er,
		input tx_take, clk_running, rx_data, rx_valid, rx_err, ib_status);
	modport tx (input speed, run, tx_data, tx_valid, tx_er, output tx_take, clk_running);
	modport rx (input speed, output rx_data, rx_valid, rx_err, ib_status);
endinterface : pmb_link_if

//--- verilog/pmb_phy_mac_ctrl.sv
// MAC-side controller: AXI4-Lite registers, device register sequencer, RGMII ends
`timescale 1ns/1ps
module pmb_phy_mac_ctrl (
	input wire logic CLOCK_IN,
	input wire logic RST_N_IN,
	input wire logic [7:0] AWADDR_IN,
	input wire logic AWVALID_IN,
	output logic AWREADY_OUT,
	input wire logic [31:0] WDATA_IN,
	input wire logic [3:0] WSTRB_IN,
	input wire logic WVALID_IN,
	output logic WREADY_OUT,
	output logic [1:0] BRESP_OUT,
	output logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic [7:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	output logic ARREADY_OUT,
	output logic [31:0] RDATA_OUT,
	output logic [1:0] RRESP_OUT,
	output logic RVALID_OUT,
	input wire logic RREADY_IN,
	output logic GIGABIT_TRANSMIT_CLOCK_OUT,
	output logic [3:0] TXD_OUT,
	output logic TX_CTRL_OUT,
	input wire logic RX_CLK_IN,
	input wire logic [3:0] RXD_IN,
	input wire logic RX_CTRL_IN,
	input wire logic [7:0] TX_DATA_IN,
	input wire logic TX_VALID_IN,
	input wire logic TX_ERROR_IN,
	output logic TX_READY_OUT,
	output logic [7:0] RX_DATA_OUT,
	output logic RX_VALID_OUT,
	output logic RX_ERROR_OUT,
	output logic DEV_REQ_OUT,
	output logic DEV_WRITE_OUT,
	output logic [8:0] DEV_ADDR_OUT,
	output logic [15:0] DEV_WDATA_OUT,
	input wire logic DEV_ACK_IN,
	input wire logic [15:0] DEV_RDATA_IN
);
	//==============================================================
	// State
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SINGLE = 2'b01,
		ST_MII_MUX = 2'b10,
		ST_MII_MODE = 2'b11
	} pmb_dev_state_t;
	typedef struct packed {
		logic [pmb_pkg::CTRL_W-1:0] ctrl;
		pmb_dev_state_t st;
		logic [8:0] dev_addr;
		logic dev_write;
		logic [15:0] dev_wdata;
		logic [15:0] dev_rdata;
		logic [15:0] rx_bytes;
		logic [15:0] rx_errs;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} pmb_top_state_t;
	pmb_top_state_t s_reg, s_next;
	pmb_link_if link ();
	pmb_pkg::pmb_speed_t speed;
	logic wr_go, rd_go, busy, refused, mismatch, rd_hit;
	logic [1:0] mc_code;
	logic [31:0] status;
	logic [31:0] rd_word;
	// Byte lanes of the device data word; upper lanes have no storage
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] be);
		merge16 = old;
		for (int i = 0; i < 2; i++) begin
			if (be[i])
				merge16[8*i +: 8] = d[8*i +: 8];
		end
	endfunction : merge16
	//==============================================================
	// Combinational decode
	always_comb begin
		wr_go = AWVALID_IN && WVALID_IN && !s_reg.bvalid;
		rd_go = ARVALID_IN && !s_reg.rvalid;
		busy = (s_reg.st != ST_IDLE);
		speed = pmb_pkg::pmb_speed_t'(s_reg.ctrl[pmb_pkg::CTRL_SPEED_LSB +: 2]);
		// No 125MHz can be made from this clock, so gigabit is refused outright
		refused = !(speed == pmb_pkg::PMB_SPD_10 || speed == pmb_pkg::PMB_SPD_100);
		mc_code = s_reg.ctrl[pmb_pkg::CTRL_MC_1000] ? 2'(pmb_pkg::PMB_SPD_1000)
			: 2'(pmb_pkg::PMB_SPD_100);
		mismatch = s_reg.ctrl[pmb_pkg::CTRL_MC_CHECK] && link.ib_status[pmb_pkg::IB_LINK]
			&& (link.ib_status[pmb_pkg::IB_SPD_LSB +: 2] != mc_code);
		status = 32'h0;
		status[pmb_pkg::ST_IB_LSB +: 4] = link.ib_status;
		status[pmb_pkg::ST_MISMATCH] = mismatch;
		status[pmb_pkg::ST_BUSY] = busy;
		status[pmb_pkg::ST_CLK_RUN] = link.clk_running;
		status[pmb_pkg::ST_REFUSED] = refused;
		rd_word = 32'h0;
		rd_hit = 1'b1;
		case (ARADDR_IN)
			pmb_pkg::REG_CTRL: begin
				rd_word[pmb_pkg::CTRL_W-1:0] = s_reg.ctrl;
			end
			pmb_pkg::REG_STATUS: begin
				rd_word = status;
			end
			pmb_pkg::REG_DEV_CMD: begin
				rd_word[8:0] = s_reg.dev_addr;
				rd_word[pmb_pkg::CMD_WRITE] = s_reg.dev_write;
			end
			pmb_pkg::REG_DEV_DATA: begin
				rd_word = {s_reg.dev_rdata, s_reg.dev_wdata};
			end
			pmb_pkg::REG_RX_COUNT: begin
				rd_word = {s_reg.rx_errs, s_reg.rx_bytes};
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end
	//==============================================================
	// Next state
	always_comb begin
		s_next = s_reg;
		if (s_reg.bvalid && BREADY_IN)
			s_next.bvalid = 1'b0;
		if (s_reg.rvalid && RREADY_IN)
			s_next.rvalid = 1'b0;
		if (link.rx_valid)
			s_next.rx_bytes = s_reg.rx_bytes + 16'h1;
		if (link.rx_valid && link.rx_err)
			s_next.rx_errs = s_reg.rx_errs + 16'h1;
		// Device register sequencer; request holds until acknowledged
		case (s_reg.st)
			ST_IDLE: begin
				s_next.st = ST_IDLE;
			end
			ST_SINGLE: begin
				if (DEV_ACK_IN) begin
					if (!s_reg.dev_write)
						s_next.dev_rdata = DEV_RDATA_IN;
					s_next.st = ST_IDLE;
				end
			end
			ST_MII_MUX: begin
				if (DEV_ACK_IN) begin
					s_next.dev_addr = pmb_pkg::DEV_OPERATING_MODE_SELECT;
					s_next.dev_wdata = s_reg.ctrl[pmb_pkg::CTRL_FIBER]
						? pmb_pkg::OPMODE_MII_FIBER : pmb_pkg::OPMODE_MII_COPPER;
					s_next.st = ST_MII_MODE;
				end
			end
			ST_MII_MODE: begin
				if (DEV_ACK_IN)
					s_next.st = ST_IDLE;
			end
			default: begin
				s_next.st = ST_IDLE;
			end
		endcase
		if (wr_go) begin
			s_next.bvalid = 1'b1;
			s_next.bresp = pmb_pkg::RESP_OKAY;
			case (AWADDR_IN)
				pmb_pkg::REG_CTRL: begin
					if (WSTRB_IN[0])
						s_next.ctrl = WDATA_IN[pmb_pkg::CTRL_W-1:0];
				end
				pmb_pkg::REG_STATUS: begin
					s_next.bresp = pmb_pkg::RESP_OKAY;
				end
				pmb_pkg::REG_DEV_CMD: begin
					// A command while the sequencer is busy is dropped
					if (!busy && WSTRB_IN[2]) begin
						if (WDATA_IN[pmb_pkg::CMD_MII]) begin
							s_next.dev_addr = pmb_pkg::DEV_LED_RX_ERROR_MUX;
							s_next.dev_wdata = pmb_pkg::MUX_RX_ERROR;
							s_next.dev_write = 1'b1;
							s_next.st = ST_MII_MUX;
						end else if (WDATA_IN[pmb_pkg::CMD_START]) begin
							s_next.dev_addr = WDATA_IN[8:0];
							s_next.dev_write = WDATA_IN[pmb_pkg::CMD_WRITE];
							s_next.st = ST_SINGLE;
						end
					end
				end
				pmb_pkg::REG_DEV_DATA: begin
					if (!busy)
						s_next.dev_wdata = merge16(s_reg.dev_wdata, WDATA_IN, WSTRB_IN);
				end
				pmb_pkg::REG_RX_COUNT: begin
					// Clear, but a byte arriving now still counts
					s_next.rx_bytes = 16'(link.rx_valid);
					s_next.rx_errs = 16'(link.rx_valid && link.rx_err);
				end
				default: begin
					s_next.bresp = pmb_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (rd_go) begin
			s_next.rvalid = 1'b1;
			s_next.rdata = rd_word;
			s_next.rresp = rd_hit ? pmb_pkg::RESP_OKAY : pmb_pkg::RESP_SLVERR;
		end
	end
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	//==============================================================
	// Link ends
	assign link.speed = speed;
	// Clock held low until software confirms the PHY speed
	assign link.run = s_reg.ctrl[pmb_pkg::CTRL_SPEED_OK] && !refused;
	assign link.tx_data = TX_DATA_IN;
	assign link.tx_valid = TX_VALID_IN;
	assign link.tx_er = TX_ERROR_IN;
	pmb_rgmii_tx u_tx (
		.clk_in(CLOCK_IN),
		.rst_n_in(RST_N_IN),
		.link(link.tx),
		.txc_out(GIGABIT_TRANSMIT_CLOCK_OUT),
		.txd_out(TXD_OUT),
		.tx_ctrl_out(TX_CTRL_OUT)
	);
	pmb_rgmii_rx u_rx (
		.clk_in(CLOCK_IN),
		.rst_n_in(RST_N_IN),
		.rx_clk_in(RX_CLK_IN),
		.rxd_in(RXD_IN),
		.rx_ctrl_in(RX_CTRL_IN),
		.link(link.rx)
	);
	//==============================================================
	// Outputs
	assign AWREADY_OUT = wr_go;
	assign WREADY_OUT = wr_go;
	assign BVALID_OUT = s_reg.bvalid;
	assign BRESP_OUT = s_reg.bresp;
	assign ARREADY_OUT = rd_go;
	assign RVALID_OUT = s_reg.rvalid;
	assign RDATA_OUT = s_reg.rdata;
	assign RRESP_OUT = s_reg.rresp;
	assign TX_READY_OUT = link.tx_take;
	assign RX_DATA_OUT = link.rx_data;
	assign RX_VALID_OUT = link.rx_valid;
	assign RX_ERROR_OUT = link.rx_err;
	assign DEV_REQ_OUT = busy;
	assign DEV_WRITE_OUT = s_reg.dev_write;
	assign DEV_ADDR_OUT = s_reg.dev_addr;
	assign DEV_WDATA_OUT = s_reg.dev_wdata;
	//==============================================================
	// Checks
	mii_mux_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		s_reg.st == ST_MII_MUX |-> DEV_REQ_OUT && DEV_WRITE_OUT
		&& DEV_ADDR_OUT == pmb_pkg::DEV_LED_RX_ERROR_MUX
		&& DEV_WDATA_OUT == pmb_pkg::MUX_RX_ERROR) else $error("bad mux write");
	mii_mode_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		s_reg.st == ST_MII_MUX && DEV_ACK_IN |=> s_reg.st == ST_MII_MODE
		&& DEV_ADDR_OUT == pmb_pkg::DEV_OPERATING_MODE_SELECT
		&& DEV_WDATA_OUT == ($past(s_reg.ctrl[pmb_pkg::CTRL_FIBER])
		? pmb_pkg::OPMODE_MII_FIBER : pmb_pkg::OPMODE_MII_COPPER))
		else $error("bad mode write");
	gig_hold_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		refused && !GIGABIT_TRANSMIT_CLOCK_OUT |=> !GIGABIT_TRANSMIT_CLOCK_OUT)
		else $error("clock runs at refused speed");
	bresp_hold_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
		else $error("write response dropped");
endmodule : pmb_phy_mac_ctrl

//--- verilog/pmb_pkg.sv
// Constants and types shared by the MAC-side RGMII controller
//==============================================================
// Overview of operation
// - Link clocks 125MHz, 25MHz, 2.5MHz by speed; here 1000 is refused and the clock held low
// - Low nibble on rising, high nibble on falling
// - Transmit control: enable rising, enable xor error falling
// - Transmit control high in frame, low between frames
// - MAC sources transmit clock, PHY receive clock
// - At 10/100 nibble repeats on falling edge
// - Transmit clock low until speed confirmed
// - MII only at 10/100; no gigabit
// - MII entry: mux 0xE, then mode 0x60/0x62
// - Bridge modes: no PRBS; LEDs show RGMII
// - Converter: copper speed must equal fiber speed
package pmb_pkg;
	//==============================================================
	// Clocking
	localparam int CLK_HZ = 50_000_000;
	localparam int RATE_1000_HZ = 125_000_000;
	localparam int RATE_100_HZ = 25_000_000;
	localparam int RATE_10_HZ = 2_500_000;
	localparam logic [3:0] HALF_100 = 4'(CLK_HZ / (2 * RATE_100_HZ));
	localparam logic [3:0] HALF_10 = 4'(CLK_HZ / (2 * RATE_10_HZ));
	typedef enum logic [1:0] {
		PMB_SPD_10 = 2'b00,
		PMB_SPD_100 = 2'b01,
		PMB_SPD_1000 = 2'b10
	} pmb_speed_t;
	//==============================================================
	// Own register map (byte addresses) and fields
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_DEV_CMD = 8'h08;
	localparam logic [7:0] REG_DEV_DATA = 8'h0c;
	localparam logic [7:0] REG_RX_COUNT = 8'h10;
	localparam int CTRL_W = 6;
	localparam int CTRL_SPEED_LSB = 0;
	localparam int CTRL_SPEED_OK = 2;
	localparam int CTRL_FIBER = 3;
	localparam int CTRL_MC_CHECK = 4;
	localparam int CTRL_MC_1000 = 5;
	localparam int ST_IB_LSB = 0;
	localparam int ST_MISMATCH = 4;
	localparam int ST_BUSY = 5;
	localparam int ST_CLK_RUN = 6;
	localparam int ST_REFUSED = 7;
	localparam int CMD_WRITE = 16;
	localparam int CMD_START = 17;
	localparam int CMD_MII = 18;
	localparam int IB_LINK = 0;
	localparam int IB_SPD_LSB = 1;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	//==============================================================
	// Device register map and values
	localparam logic [8:0] DEV_BASIC_PHY_CONTROL = 9'h000;
	localparam logic [8:0] DEV_LED_RX_ERROR_MUX = 9'h018;
	localparam logic [8:0] DEV_MAC_IF_TIMING_MODE = 9'h032;
	localparam logic [8:0] DEV_MAC_IF_DELAY_SELECT = 9'h086;
	localparam logic [8:0] DEV_OPERATING_MODE_SELECT = 9'h1df;
	localparam logic [15:0] MUX_RX_ERROR = 16'h000e;
	localparam logic [15:0] OPMODE_MII_COPPER = 16'h0060;
	localparam logic [15:0] OPMODE_MII_FIBER = 16'h0062;
endpackage : pmb_pkg

//--- verilog/pmb_rgmii_rx.sv
// RGMII receive end: pin synchronisers, edge capture, byte assembly, in-band status
`timescale 1ns/1ps
module pmb_rgmii_rx (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic rx_clk_in,
	input wire logic [3:0] rxd_in,
	input wire logic rx_ctrl_in,
	pmb_link_if.rx link
);
	typedef struct packed {
		logic [5:0] s1;
		logic [5:0] s2;
		logic [5:0] s3;
		logic [3:0] lo;
		logic ctl_r;
		logic hi_half;
		logic [7:0] data;
		logic valid;
		logic err;
		logic [3:0] ib;
	} pmb_rx_state_t;
	pmb_rx_state_t s_reg, s_next;
	logic rise, fall, dv, er;
	always_comb begin
		// Edges from the second stage, so a stretched phase only delays capture
		rise = s_reg.s2[5] && !s_reg.s3[5];
		fall = !s_reg.s2[5] && s_reg.s3[5];
		dv = s_reg.ctl_r;
		er = s_reg.ctl_r ^ s_reg.s2[4];
		s_next = s_reg;
		s_next.s1 = {rx_clk_in, rx_ctrl_in, rxd_in};
		s_next.s2 = s_reg.s1;
		s_next.s3 = s_reg.s2;
		s_next.valid = 1'b0;
		if (rise) begin
			s_next.lo = s_reg.s2[3:0];
			s_next.ctl_r = s_reg.s2[4];
		end
		if (fall) begin
			s_next.err = er;
			if (link.speed == pmb_pkg::PMB_SPD_1000) begin
				s_next.data = {s_reg.s2[3:0], s_reg.lo};
				s_next.valid = dv;
			end else if (dv) begin
				s_next.data = {s_reg.lo, s_reg.data[7:4]};
				s_next.valid = s_reg.hi_half;
				s_next.hi_half = !s_reg.hi_half;
			end else begin
				s_next.hi_half = 1'b0;
				if (!er)
					s_next.ib = s_reg.lo;
			end
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	assign link.rx_data = s_reg.data;
	assign link.rx_valid = s_reg.valid;
	assign link.rx_err = s_reg.err;
	assign link.ib_status = s_reg.ib;
	//==============================================================
	// Checks
	lo_capture_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rise |=> s_reg.lo == $past(s_reg.s2[3:0])) else $error("low nibble not captured");
	inband_take_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		fall && !s_reg.ctl_r && !s_reg.s2[4] && link.speed != pmb_pkg::PMB_SPD_1000
		|=> s_reg.ib == $past(s_reg.lo))
		else $error("in-band status not taken");
endmodule : pmb_rgmii_rx

//--- verilog/pmb_rgmii_tx.sv
// RGMII transmit end: divided clock, nibble and control encoding
`timescale 1ns/1ps
module pmb_rgmii_tx (
	input wire logic clk_in,
	input wire logic rst_n_in,
	pmb_link_if.tx link,
	output logic txc_out,
	output logic [3:0] txd_out,
	output logic tx_ctrl_out
);
	typedef struct packed {
		logic [3:0] cnt;
		logic clk;
		logic hi_half;
		logic en;
		logic er;
		logic [7:0] byte_q;
		logic [3:0] txd;
		logic ctrl;
	} pmb_tx_state_t;
	pmb_tx_state_t s_reg, s_next;
	logic [3:0] half;
	logic expire, rise_evt, fall_evt, take;
	always_comb begin
		half = (link.speed == pmb_pkg::PMB_SPD_10) ? pmb_pkg::HALF_10 : pmb_pkg::HALF_100;
		// At or past the end, so a switch to a shorter half never runs the count round
		expire = (s_reg.cnt >= half - 4'h1);
		// Rise only when allowed; a started high phase always completes, so no runt pulse
		rise_evt = expire && !s_reg.clk && link.run;
		fall_evt = expire && s_reg.clk;
		take = fall_evt && !s_reg.hi_half && link.tx_valid && link.run;
		s_next = s_reg;
		s_next.cnt = (expire || (!link.run && !s_reg.clk)) ? 4'h0 : s_reg.cnt + 4'h1;
		if (rise_evt) begin
			s_next.clk = 1'b1;
			s_next.ctrl = s_reg.en ^ s_reg.er;
		end
		// Data changes with the clock edge; the PHY's default shift centres it
		if (fall_evt) begin
			s_next.clk = 1'b0;
			if (s_reg.hi_half) begin
				s_next.txd = s_reg.byte_q[7:4];
				s_next.hi_half = 1'b0;
			end else begin
				s_next.en = take;
				s_next.er = take && link.tx_er;
				s_next.byte_q = link.tx_data;
				s_next.txd = take ? link.tx_data[3:0] : 4'h0;
				s_next.hi_half = take;
			end
			s_next.ctrl = s_next.en;
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	assign link.tx_take = take;
	assign link.clk_running = link.run;
	assign txc_out = s_reg.clk;
	assign txd_out = s_reg.txd;
	assign tx_ctrl_out = s_reg.ctrl;
	//==============================================================
	// Checks
	clk_hold_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!link.run && !s_reg.clk |=> !s_reg.clk) else $error("clock rose while stopped");
	ctrl_rise_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(s_reg.clk) |-> $past(s_reg.ctrl) == s_reg.en) else $error("bad rising control");
	ctrl_fall_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(s_reg.clk) |-> $past(s_reg.ctrl) == ($past(s_reg.en) ^ $past(s_reg.er)))
		else $error("bad falling control");
	nibble_repeat_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(s_reg.clk) |-> $stable(s_reg.txd)) else $error("nibble changed at rise");
	idle_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!s_reg.en && !s_reg.er |-> !s_reg.ctrl) else $error("control high while idle");
	period_100_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		s_reg.clk && link.speed == pmb_pkg::PMB_SPD_100 |=> !s_reg.clk)
		else $error("25MHz high phase too long");
endmodule : pmb_rgmii_tx
